// >>> ecs_top.sv
`timescale 1ns/10ps
// Contract
// - busy high while any attached user owes event
// - ready bit set only when all attached users ready
// - clear-enable write one disables event interrupt
// - clear-enable write one disables overrun interrupt
// - set-enable write one enables event interrupt
// - set-enable write one enables overrun interrupt
// - both enable registers read shared mask
// - event enables 15..8, overrun 7..0, reset zero
// - event flag sets next cycle, requests interrupt
// - async path never sets event flag
// - overrun flag sets next cycle, requests interrupt
// - async path never sets overrun flag
// - flag write one clears event flag
// - flag write one clears overrun flag
// - flags 15..8 event, 7..0 overrun, reset zero
module ecs_top #(
  parameter int NUM_USERS = ecs_pkg::NUM_USERS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // avalon-mm slave
  input wire logic [ecs_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [ecs_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [ecs_pkg::BE_W-1:0] avs_byteenable_i,
  output logic [ecs_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // channel events from the routing logic
  input wire logic [ecs_pkg::NUM_CH-1:0] chan_event_i,
  input wire logic [ecs_pkg::NUM_CH-1:0] chan_overrun_i,
  // event users
  input wire logic [ecs_pkg::NUM_CH-1:0][NUM_USERS-1:0] user_attach_i,
  input wire logic [NUM_USERS-1:0] user_ready_i,
  input wire logic [NUM_USERS-1:0] user_taken_i,
  // interrupt
  output logic irq_o
);
  // ==========================================================
  // declarations
  // ==========================================================
  ecs_pkg::ecs_bus_state_t state_q; // bus slave phase
  ecs_pkg::ecs_bus_state_t state_d;
  logic bus_req; // read or write held by the master
  logic wr_fire; // edge at which a write takes effect
  logic rd_take; // read sampled in the first cycle
  logic [ecs_pkg::MASK_W-1:0] wr_mask; // written ones, lane gated
  logic [ecs_pkg::MASK_W-1:0] en_q; // shared enable mask
  logic [ecs_pkg::NUM_CH-1:0] path_async_q; // per channel async path
  logic [ecs_pkg::NUM_CH-1:0] pending; // channel busy
  logic [ecs_pkg::NUM_CH-1:0] all_ready; // users all ready
  logic [ecs_pkg::MASK_W-1:0] flags; // packed flag view
  logic [ecs_pkg::DATA_W-1:0] rd_word; // read mux output
  logic [ecs_pkg::DATA_W-1:0] readdata_q; // registered read data
  logic fire_clr; // write to enable clear
  logic fire_set; // write to enable set
  logic fire_flags; // write to flag register
  logic fire_path; // write to path config
  logic [ecs_pkg::NUM_CH-1:0] has_users; // any user attached, per channel

  ecs_flag_if fl ();

  // ==========================================================
  // bus phase machine
  // ==========================================================
  // one wait state: read data is latched in the first cycle
  // so it comes from a flip-flop when waitrequest drops
  assign bus_req = avs_read_i | avs_write_i;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ecs_pkg::BUS_IDLE:
      begin
        // accept any request held by the master
        if (bus_req)
        begin
          state_d = ecs_pkg::BUS_ANSWER;
        end
      end
      ecs_pkg::BUS_ANSWER:
      begin
        // answer edge, request released afterwards
        state_d = ecs_pkg::BUS_IDLE;
      end
    endcase
  end

  // phase register
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q <= ecs_pkg::BUS_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign avs_waitrequest_o = bus_req & (state_q == ecs_pkg::BUS_IDLE);
  assign wr_fire = avs_write_i & (state_q == ecs_pkg::BUS_ANSWER);
  assign rd_take = avs_read_i & (state_q == ecs_pkg::BUS_IDLE);

  // ==========================================================
  // write decode
  // ==========================================================
  // only the two low lanes hold bits; upper lanes are ignored
  assign wr_mask = avs_writedata_i[ecs_pkg::MASK_W-1:0]
    & {{ecs_pkg::LANE_W{avs_byteenable_i[1]}},
       {ecs_pkg::LANE_W{avs_byteenable_i[0]}}};
  assign fire_clr = wr_fire & (avs_address_i == ecs_pkg::OFS_EN_CLR);
  assign fire_set = wr_fire & (avs_address_i == ecs_pkg::OFS_EN_SET);
  assign fire_flags = wr_fire & (avs_address_i == ecs_pkg::OFS_FLAGS);
  assign fire_path = wr_fire & (avs_address_i == ecs_pkg::OFS_PATH);

  // ==========================================================
  // interrupt enable mask
  // ==========================================================
  // set and clear are separate addresses, so never both at once
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      en_q <= ecs_pkg::MASK_RST;
    end
    else if (fire_set)
    begin
      en_q <= en_q | wr_mask;
    end
    else if (fire_clr)
    begin
      en_q <= en_q & ~wr_mask;
    end
  end

  // ==========================================================
  // path configuration
  // ==========================================================
  // one bit per channel: high selects the asynchronous path
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      path_async_q <= ecs_pkg::PATH_RST;
    end
    else if (fire_path && avs_byteenable_i[0])
    begin
      path_async_q <= avs_writedata_i[ecs_pkg::NUM_CH-1:0];
    end
  end

  // ==========================================================
  // channel status tracking
  // ==========================================================
  ecs_chan_track #(
    .NCH(ecs_pkg::NUM_CH),
    .NUSR(NUM_USERS)
  ) u_track (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .event_i(chan_event_i),
    .attach_i(user_attach_i),
    .ready_i(user_ready_i),
    .taken_i(user_taken_i),
    .pending_o(pending),
    .all_ready_o(all_ready)
  );

  // ==========================================================
  // flag bank
  // ==========================================================
  // a new event on a still busy channel also counts as overrun
  assign fl.evt_set = chan_event_i;
  assign fl.ovr_set = chan_overrun_i | (chan_event_i & pending);
  assign fl.async_path = path_async_q;
  assign fl.evt_clr = fire_flags
    ? wr_mask[ecs_pkg::EVD_LSB +: ecs_pkg::NUM_CH] : '0;
  assign fl.ovr_clr = fire_flags
    ? wr_mask[ecs_pkg::OVR_LSB +: ecs_pkg::NUM_CH] : '0;

  ecs_flag_bank u_flags (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .fl(fl)
  );

  assign flags = {fl.evt_flag, fl.ovr_flag};

  // ==========================================================
  // interrupt output
  // ==========================================================
  assign irq_o = |(flags & en_q);

  // ==========================================================
  // read mux and read data register
  // ==========================================================
  // unmapped addresses read zero and drop writes
  always_comb
  begin
    rd_word = ecs_pkg::RD_RST;
    case (avs_address_i)
      ecs_pkg::OFS_STATE:
      begin
        rd_word = ecs_pkg::DATA_W'({pending, all_ready});
      end
      ecs_pkg::OFS_EN_CLR, ecs_pkg::OFS_EN_SET:
      begin
        rd_word = ecs_pkg::DATA_W'(en_q);
      end
      ecs_pkg::OFS_FLAGS:
      begin
        rd_word = ecs_pkg::DATA_W'(flags);
      end
      ecs_pkg::OFS_PATH:
      begin
        rd_word = ecs_pkg::DATA_W'(path_async_q);
      end
      default:
      begin
        rd_word = ecs_pkg::RD_RST;
      end
    endcase
  end

  // latched in the wait cycle, stands until the next read
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      readdata_q <= ecs_pkg::RD_RST;
    end
    else if (rd_take)
    begin
      readdata_q <= rd_word;
    end
  end

  assign avs_readdata_o = readdata_q;

  // ==========================================================
  // assertions
  // ==========================================================
  a_evd_set_next: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (chan_event_i & ~path_async_q) != '0
    |=> (fl.evt_flag & $past(chan_event_i & ~path_async_q))
        == $past(chan_event_i & ~path_async_q))
    else $error("event seen flag not set after event");

  a_evd_async_quiet: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ##1 (fl.evt_flag & ~$past(fl.evt_flag)
         & $past(path_async_q)) == '0)
    else $error("event seen flag rose on async channel");

  a_ovr_set_next: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (chan_overrun_i & ~path_async_q) != '0
    |=> (fl.ovr_flag & $past(chan_overrun_i & ~path_async_q))
        == $past(chan_overrun_i & ~path_async_q))
    else $error("overrun flag not set after overrun");

  a_ovr_async_quiet: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ##1 (fl.ovr_flag & ~$past(fl.ovr_flag)
         & $past(path_async_q)) == '0)
    else $error("overrun flag rose on async channel");

  a_evd_clear_one: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    fire_flags && (fl.evt_set & fl.evt_clr) == '0
    |=> (fl.evt_flag & $past(fl.evt_clr)) == '0)
    else $error("event seen flag survived a clear");

  a_ovr_clear_one: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    fire_flags && (fl.ovr_set & fl.ovr_clr) == '0
    |=> (fl.ovr_flag & $past(fl.ovr_clr)) == '0)
    else $error("overrun flag survived a clear");

  a_en_set_bits: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    fire_set |=> (en_q & $past(wr_mask)) == $past(wr_mask)
      && (en_q & ~$past(wr_mask)) == ($past(en_q) & ~$past(wr_mask)))
    else $error("enable set write wrong");

  a_en_clr_bits: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    fire_clr |=> (en_q & $past(wr_mask)) == '0
      && (en_q & ~$past(wr_mask)) == ($past(en_q) & ~$past(wr_mask)))
    else $error("enable clear write wrong");

  a_en_read_mask: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    rd_take && (avs_address_i == ecs_pkg::OFS_EN_SET
      || avs_address_i == ecs_pkg::OFS_EN_CLR)
    |=> avs_readdata_o == ecs_pkg::DATA_W'($past(en_q)))
    else $error("enable read does not show mask");

  a_state_read: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    rd_take && avs_address_i == ecs_pkg::OFS_STATE
    |=> avs_readdata_o
        == ecs_pkg::DATA_W'({$past(pending), $past(all_ready)}))
    else $error("channel state read mismatch");

  a_flag_read: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    rd_take && avs_address_i == ecs_pkg::OFS_FLAGS
    |=> avs_readdata_o == ecs_pkg::DATA_W'($past(flags)))
    else $error("flag read does not show flags");

  // channels with at least one user, so every channel is watched
  // and not just the one that a test happens to use
  always_comb
  begin
    for (int c = 0; c < ecs_pkg::NUM_CH; c++)
    begin
      has_users[c] = |user_attach_i[c];
    end
  end

  a_busy_on_event: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (chan_event_i & has_users) != '0
    |=> (pending & $past(chan_event_i & has_users))
        == $past(chan_event_i & has_users))
    else $error("channel not busy after event");

  a_irq_follows: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (fl.evt_set & ~path_async_q
      & en_q[ecs_pkg::EVD_LSB +: ecs_pkg::NUM_CH]) != '0
      && !wr_fire
    |=> irq_o)
    else $error("interrupt missing after enabled event");

  a_wait_once: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    $rose(bus_req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("waitrequest not exactly one cycle");
endmodule

// >>> ecs_pkg.sv
package ecs_pkg;
  // ==========================================================
  // sizes
  // ==========================================================
  localparam int NUM_CH = 8; // channel count, fixed by the layout
  localparam int NUM_USERS = 4; // default number of event users
  localparam int ADDR_W = 5; // byte address width of the slave
  localparam int DATA_W = 32; // bus data width
  localparam int BE_W = 4; // byte enables
  localparam int LANE_W = 8; // bits per byte lane
  localparam int MASK_W = 16; // used width of enable and flags
  // field positions inside the 16 used bits
  localparam int EVD_LSB = 8; // event seen bits 15..8
  localparam int OVR_LSB = 0; // overrun bits 7..0
  // ==========================================================
  // register map (byte addresses)
  // ==========================================================
  localparam logic [ADDR_W-1:0] OFS_STATE = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_EN_CLR = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_EN_SET = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_PATH = 5'h1C;
  // reset values
  localparam logic [MASK_W-1:0] MASK_RST = 16'h0000;
  localparam logic [NUM_CH-1:0] PATH_RST = 8'h00;
  localparam logic [NUM_CH-1:0] FLAG_RST = 8'h00;
  localparam logic [DATA_W-1:0] RD_RST = 32'h0000_0000;
  // ==========================================================
  // bus slave states
  // ==========================================================
  typedef enum {BUS_IDLE, BUS_ANSWER} ecs_bus_state_t;
endpackage

// >>> ecs_flag_if.sv
`timescale 1ns/10ps
// ============================================================
// sticky flag bank connection
// ============================================================
interface ecs_flag_if;
  logic [ecs_pkg::NUM_CH-1:0] evt_set; // event passed, per channel
  logic [ecs_pkg::NUM_CH-1:0] ovr_set; // overrun condition
  logic [ecs_pkg::NUM_CH-1:0] async_path; // channel on async path
  logic [ecs_pkg::NUM_CH-1:0] evt_clr; // write one to clear
  logic [ecs_pkg::NUM_CH-1:0] ovr_clr; // write one to clear
  logic [ecs_pkg::NUM_CH-1:0] evt_flag; // event seen flags
  logic [ecs_pkg::NUM_CH-1:0] ovr_flag; // overrun flags
  modport bank (
    input evt_set, ovr_set, async_path, evt_clr, ovr_clr,
    output evt_flag, ovr_flag
  );
  modport ctrl (
    output evt_set, ovr_set, async_path, evt_clr, ovr_clr,
    input evt_flag, ovr_flag
  );
endinterface

// >>> ecs_flag_bank.sv
`timescale 1ns/10ps
module ecs_flag_bank (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // flag controls and flags
  ecs_flag_if.bank fl
);
  // ==========================================================
  // event seen flags
  // ==========================================================
  // a set arriving with a clear wins, so no event is lost
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      fl.evt_flag <= ecs_pkg::FLAG_RST;
    end
    else
    begin
      fl.evt_flag <= (fl.evt_flag & ~fl.evt_clr)
                   | (fl.evt_set & ~fl.async_path);
    end
  end

  // ==========================================================
  // overrun flags
  // ==========================================================
  // single clock here, so the event clock edge is the bus edge
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      fl.ovr_flag <= ecs_pkg::FLAG_RST;
    end
    else
    begin
      fl.ovr_flag <= (fl.ovr_flag & ~fl.ovr_clr)
                   | (fl.ovr_set & ~fl.async_path);
    end
  end
endmodule

// >>> ecs_chan_track.sv
`timescale 1ns/10ps
module ecs_chan_track #(
  parameter int NCH = 8,
  parameter int NUSR = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // channel events and user side
  input wire logic [NCH-1:0] event_i,
  input wire logic [NCH-1:0][NUSR-1:0] attach_i,
  input wire logic [NUSR-1:0] ready_i,
  input wire logic [NUSR-1:0] taken_i,
  // per channel status
  output logic [NCH-1:0] pending_o,
  output logic [NCH-1:0] all_ready_o
);
  // users that still owe a channel its last event
  logic [NCH-1:0][NUSR-1:0] owed_q;

  // a detached user never holds a channel back
  function automatic logic all_set(
    input logic [NUSR-1:0] rdy,
    input logic [NUSR-1:0] att
  );
    all_set = &(rdy | ~att);
  endfunction

  // ==========================================================
  // outstanding users per channel
  // ==========================================================
  // a new event reloads the owed set, winning over a take
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      owed_q <= '0;
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (event_i[c])
        begin
          owed_q[c] <= attach_i[c];
        end
        else
        begin
          owed_q[c] <= owed_q[c] & ~taken_i & attach_i[c];
        end
      end
    end
  end

  // ==========================================================
  // status outputs
  // ==========================================================
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      pending_o[c] = |owed_q[c];
      all_ready_o[c] = all_set(ready_i, attach_i[c]);
    end
  end
endmodule

// >>> ecs_evt_model.sv
`timescale 1ns/10ps
// ==========================================================
// event generators and event users beside the block
// ==========================================================
module ecs_evt_model (
  // clock
  input wire logic clk_i,
  // generator side
  output logic [ecs_pkg::NUM_CH-1:0] event_o,
  output logic [ecs_pkg::NUM_CH-1:0] overrun_o,
  // user side
  output logic [ecs_pkg::NUM_CH-1:0][ecs_pkg::NUM_USERS-1:0] attach_o,
  output logic [ecs_pkg::NUM_USERS-1:0] ready_o,
  output logic [ecs_pkg::NUM_USERS-1:0] taken_o
);
  // quiet at time zero: nothing attached, every user ready
  initial
  begin
    event_o = 8'h00;
    overrun_o = 8'h00;
    attach_o = 32'h0000_0000;
    ready_o = 4'hF;
    taken_o = 4'h0;
  end
  // one-cycle pulse launched after an edge; kind 0 event,
  // 1 overrun, 2 user taken; returns at the sampling edge
  task automatic pulse(input logic [1:0] kind, input logic [7:0] m);
    @(posedge clk_i);
    if (kind == 2'h0)
      event_o <= m;
    else if (kind == 2'h1)
      overrun_o <= m;
    else
      taken_o <= m[3:0];
    @(posedge clk_i);
    event_o <= 8'h00;
    overrun_o <= 8'h00;
    taken_o <= 4'h0;
  endtask
  // attachment and readiness are levels, changed after an edge
  task automatic users(input logic [31:0] att, input logic [3:0] rdy);
    @(posedge clk_i);
    attach_o <= att;
    ready_o <= rdy;
  endtask
endmodule

// >>> event_channel_status_irq_bench.sv
`timescale 1ns/10ps
module event_channel_status_irq_bench;
  // ==========================================================
  // clock, reset and bus master signals
  // ==========================================================
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [4:0] avs_addr = 5'h00;
  logic avs_rd = 1'b0;
  logic avs_wr = 1'b0;
  logic [31:0] avs_wdata = 32'h0000_0000;
  logic [3:0] avs_be = 4'hF; // all lanes unless a test narrows it
  logic [31:0] avs_rdata;
  logic avs_wait;
  logic irq;
  // partner lines
  logic [7:0] ev;
  logic [7:0] ov;
  logic [7:0][3:0] att;
  logic [3:0] rdy;
  logic [3:0] tkn;
  // bus answer as it stands at the coming rising edge
  logic wait_s = 1'b1;
  logic [31:0] rd_s = 32'h0000_0000;
  int err_total = 0;
  int cmp_count = 0;
  // 10 MHz clock
  always #50 clk_i = ~clk_i;
  // inputs move only at rising edges, so the falling edge sees
  // exactly what the next rising edge will sample
  always @(negedge clk_i)
  begin
    wait_s = avs_wait;
    rd_s = avs_rdata;
  end
  // ==========================================================
  // design and partner
  // ==========================================================
  ecs_top i_ecs_top (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .avs_address_i(avs_addr),
    .avs_read_i(avs_rd),
    .avs_write_i(avs_wr),
    .avs_writedata_i(avs_wdata),
    .avs_byteenable_i(avs_be),
    .avs_readdata_o(avs_rdata),
    .avs_waitrequest_o(avs_wait),
    .chan_event_i(ev),
    .chan_overrun_i(ov),
    .user_attach_i(att),
    .user_ready_i(rdy),
    .user_taken_i(tkn),
    .irq_o(irq)
  );
  ecs_evt_model i_ecs_evt_model (
    .clk_i(clk_i),
    .event_o(ev),
    .overrun_o(ov),
    .attach_o(att),
    .ready_o(rdy),
    .taken_o(tkn)
  );
  // ==========================================================
  // checking and closing
  // ==========================================================
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one avalon transfer: held until waitrequest is seen low
  task automatic bus_xfer(input logic wr, input logic [4:0] a,
                          input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    avs_addr <= a;
    avs_wr <= wr;
    avs_rd <= ~wr;
    avs_wdata <= d;
    // no cycle count assumed; a slave that never answers is
    // left to the hang guard
    do
    begin
      @(posedge clk_i);
    end
    while (wait_s !== 1'b0);
    q = rd_s;
    avs_rd <= 1'b0;
    avs_wr <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp,
                        input string what);
    logic [31:0] q;
    bus_xfer(1'b0, a, 32'h0000_0000, q);
    check(what, q, exp);
  endtask
  // settled interrupt line, one step after the last edge
  task automatic irq_chk(input logic e, input string what);
    #1;
    check(what, {31'h0, irq}, {31'h0, e});
  endtask
  // hang guard: the sequence needs well under 2000 cycles
  initial
  begin
    #1000000;
    err_total++;
    end_sim();
  end
  // ==========================================================
  // test sequence
  // ==========================================================
  initial
  begin
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    // reset values and an unmapped hole
    rd_chk(5'h10, 32'h0000_0000, "enable_clear_rst");
    rd_chk(5'h14, 32'h0000_0000, "enable_set_rst");
    rd_chk(5'h18, 32'h0000_0000, "flags_rst");
    rd_chk(5'h04, 32'h0000_0000, "unmapped");
    rd_chk(5'h0C, 32'h0000_00FF, "state_idle");
    // set, clear and zero writes on the shared mask
    wr(5'h14, 32'hFFFF_A5C3);
    rd_chk(5'h14, 32'h0000_A5C3, "set_mask");
    rd_chk(5'h10, 32'h0000_A5C3, "clear_view");
    wr(5'h10, 32'h0000_8001);
    rd_chk(5'h14, 32'h0000_25C2, "clear_bits");
    wr(5'h10, 32'h0000_0000);
    wr(5'h14, 32'h0000_0000);
    rd_chk(5'h10, 32'h0000_25C2, "zero_writes");
    // every flag raised with all interrupts masked
    wr(5'h10, 32'h0000_FFFF);
    for (int n = 0; n < 8; n++)
    begin
      i_ecs_evt_model.pulse(2'h0, 8'h01 << n);
      i_ecs_evt_model.pulse(2'h1, 8'h01 << n);
    end
    irq_chk(1'b0, "irq_masked");
    rd_chk(5'h18, 32'h0000_FFFF, "all_flags");
    wr(5'h18, 32'h0000_0000);
    rd_chk(5'h18, 32'h0000_FFFF, "flag_zero_wr");
    wr(5'h14, 32'h0000_0100);
    irq_chk(1'b1, "irq_one_enable");
    wr(5'h18, 32'h0000_FEFF);
    rd_chk(5'h18, 32'h0000_0100, "flag_clear");
    wr(5'h18, 32'h0000_0100);
    irq_chk(1'b0, "irq_flag_gone");
    // interrupt one cycle after an event or an overrun
    wr(5'h14, 32'h0000_FFFF);
    i_ecs_evt_model.pulse(2'h0, 8'h20);
    irq_chk(1'b1, "irq_event");
    rd_chk(5'h18, 32'h0000_2000, "event5_flag");
    wr(5'h18, 32'h0000_FFFF);
    i_ecs_evt_model.pulse(2'h1, 8'h40);
    irq_chk(1'b1, "irq_overrun");
    rd_chk(5'h18, 32'h0000_0040, "overrun6_flag");
    wr(5'h18, 32'h0000_FFFF);
    // asynchronous path on channel 1 suppresses both flags
    wr(5'h1C, 32'h0000_0002);
    rd_chk(5'h1C, 32'h0000_0002, "path_cfg");
    i_ecs_evt_model.pulse(2'h0, 8'h02);
    i_ecs_evt_model.pulse(2'h1, 8'h02);
    irq_chk(1'b0, "irq_async");
    rd_chk(5'h18, 32'h0000_0000, "async_flags");
    wr(5'h1C, 32'h0000_0000);
    // channel 2 with users 0 and 1 attached
    wr(5'h10, 32'h0000_FFFF);
    i_ecs_evt_model.users(32'h0000_0300, 4'hD);
    rd_chk(5'h0C, 32'h0000_00FB, "user_not_ready");
    i_ecs_evt_model.users(32'h0000_0300, 4'hF);
    i_ecs_evt_model.pulse(2'h0, 8'h04);
    rd_chk(5'h0C, 32'h0000_04FF, "busy");
    i_ecs_evt_model.pulse(2'h2, 8'h01);
    rd_chk(5'h0C, 32'h0000_04FF, "one_owed");
    // a second event while still owed counts as overrun
    i_ecs_evt_model.pulse(2'h0, 8'h04);
    rd_chk(5'h18, 32'h0000_0404, "busy_overrun");
    i_ecs_evt_model.pulse(2'h2, 8'h03);
    rd_chk(5'h0C, 32'h0000_00FF, "idle_again");
    // the status word ignores writes
    wr(5'h0C, 32'h0000_FFFF);
    rd_chk(5'h0C, 32'h0000_00FF, "state_ro");
    // only lane 0 enabled: the event enables must stay clear
    avs_be <= 4'h1;
    wr(5'h14, 32'h0000_FFFF);
    avs_be <= 4'hF;
    rd_chk(5'h14, 32'h0000_00FF, "lane0_only");
    end_sim();
  end
endmodule
